// ==== rior_top.v ====
// Remote I/O error reporter: fault queue, error word, terminator check and APB registers.
`timescale 1ns/10ps
`default_nettype none
`include "rior_defines.vh"

module rior_top #(
    parameter [25:0] BLINK_HALF_CYC = `RIOR_BLINK_HALF_MS * `RIOR_CLK_KHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Fault reports from the link
    input  wire        fault_valid,
    input  wire [1:0]  fault_kind,
    input  wire [2:0]  fault_master,
    input  wire [2:0]  fault_slave,
    input  wire [4:0]  fault_term_addr,
    input  wire [1:0]  fault_word_mult,
    // Terminator detection
    input  wire        term_seen,
    input  wire [2:0]  term_master,
    input  wire [2:0]  term_slave,
    input  wire        scan_done,
    // Outputs
    output wire [15:0] error_word,
    output reg         error_flag,
    output reg         terminator_check_indicator,
    output wire        irq
);
    // ==================================================
    // Indicator states
    localparam [1:0] IND_SEARCH = 2'h0;
    localparam [1:0] IND_MULTI  = 2'h1;
    localparam [1:0] IND_SINGLE = 2'h2;

    // ==================================================
    // Encoding helpers
    function [7:0] bin_to_bcd;
        input [4:0] v;
        begin
            if (v >= 5'd30) begin
                bin_to_bcd = {4'h3, v[3:0] - 4'hE};
            end else if (v >= 5'd20) begin
                bin_to_bcd = {4'h2, v[3:0] - 4'h4};
            end else if (v >= 5'd10) begin
                bin_to_bcd = {4'h1, v[3:0] - 4'hA};
            end else begin
                bin_to_bcd = {4'h0, v[3:0]};
            end
        end
    endfunction

    // Upper byte for master or slave entries
    function [7:0] unit_byte;
        input [2:0] order;
        input       is_small;
        begin
            if (is_small) begin
                unit_byte = {`RIOR_UNIT_NIBBLE, 2'b00, order[1:0]};
            end else begin
                unit_byte = {`RIOR_UNIT_NIBBLE, 1'b0, order};
            end
        end
    endfunction

    // Slave number nibble, trimmed in the small variant
    function [3:0] slave_nib;
        input [2:0] num;
        input       is_small;
        begin
            if (is_small) begin
                slave_nib = {3'b000, num[0]};
            end else begin
                slave_nib = {1'b0, num};
            end
        end
    endfunction

    // ==================================================
    // State
    reg  [2:0]  ctrl_reg;
    reg  [3:0]  irq_stat_reg;
    reg  [3:0]  irq_mask_reg;
    reg  [3:0]  cnt_reg;
    reg  [2:0]  rd_idx_reg;
    reg  [3:0]  term_cnt_reg;
    reg  [1:0]  ind_state_reg;
    reg  [1:0]  ind_state_next;
    reg         fault_held_reg;
    reg         step_prev_reg;
    reg  [15:0] push_word;
    reg         push_ok;
    wire        blink_phase;

    // ==================================================
    // APB decode
    wire acc      = psel & penable;
    wire wr_acc   = acc & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire rd_acc   = acc & ~pwrite;
    wire mapped   = (paddr == `RIOR_OFF_CTRL) || (paddr == `RIOR_OFF_STATUS) ||
                    (paddr == `RIOR_OFF_ERRWORD) || (paddr == `RIOR_OFF_IRQ_STAT) ||
                    (paddr == `RIOR_OFF_IRQ_MASK);

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    wire wr_ctrl  = wr_acc & (paddr == `RIOR_OFF_CTRL);
    wire wr_mask  = wr_acc & (paddr == `RIOR_OFF_IRQ_MASK);
    wire rd_istat = rd_acc & (paddr == `RIOR_OFF_IRQ_STAT);
    wire scan_go  = wr_ctrl & pwdata[`RIOR_CTRL_SCAN_START];
    wire clear_go = wr_ctrl & pwdata[`RIOR_CTRL_CLEAR];
    wire is_small = ctrl_reg[`RIOR_CTRL_SMALL_VAR];

    // Either variant's step bit drives the same queue
    wire step_now  = ctrl_reg[`RIOR_CTRL_STEP_SMALL] | ctrl_reg[`RIOR_CTRL_STEP_LARGE];
    wire step_fall = step_prev_reg & ~step_now;

    // ==================================================
    // Entry encoding; a fault wins over a terminator in the same cycle
    always @* begin
        push_word = 16'h0000;
        push_ok   = 1'b0;
        if (fault_valid) begin
            if (fault_kind == `RIOR_KIND_MASTER) begin
                push_word = {unit_byte(fault_master, is_small), `RIOR_MASTER_NIBBLE, 4'h0};
                push_ok   = 1'b1;
            end else if (fault_kind == `RIOR_KIND_SLAVE) begin
                push_word = {unit_byte(fault_master, is_small),
                             slave_nib(fault_slave, is_small), 4'h0};
                push_ok   = 1'b1;
            end else if (fault_kind == `RIOR_KIND_TERMINAL) begin
                // Even code per multiplier; small variant has multiplier 0 only
                push_word = {bin_to_bcd(fault_term_addr), 1'b0,
                             (is_small ? 2'b00 : fault_word_mult), 1'b0, 4'h0};
                push_ok   = 1'b1;
            end
        end else if (term_seen && ind_state_reg != IND_SINGLE) begin
            push_word = {unit_byte(term_master, is_small), slave_nib(term_slave, is_small), 4'h0};
            push_ok   = 1'b1;
        end else if (term_seen) begin
            push_word = {unit_byte(term_master, is_small), slave_nib(term_slave, is_small), 4'h0};
            push_ok   = 1'b1;
        end
    end

    wire full      = (cnt_reg == `RIOR_DEPTH);
    wire push      = push_ok & (~full | clear_go);
    wire overflow  = push_ok & full & ~clear_go;

    // ==================================================
    // Queue pointers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg        <= 4'h0;
            rd_idx_reg     <= 3'h0;
            step_prev_reg  <= 1'b0;
            fault_held_reg <= 1'b0;
        end else if (ce) begin
            step_prev_reg <= step_now;
            if (clear_go) begin
                cnt_reg        <= {3'h0, push};
                rd_idx_reg     <= 3'h0;
                fault_held_reg <= push & fault_valid;
            end else begin
                if (push) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
                if (fault_valid && push_ok) begin
                    fault_held_reg <= 1'b1;
                end
                if (step_fall && cnt_reg != 4'h0) begin
                    if ({1'b0, rd_idx_reg} == cnt_reg - 4'h1) begin
                        rd_idx_reg <= 3'h0;
                    end else begin
                        rd_idx_reg <= rd_idx_reg + 3'h1;
                    end
                end
            end
        end
    end

    rior_fault_mem u_mem (
        .pclk  (pclk),
        .ce    (ce),
        .we    (push),
        .waddr (clear_go ? 3'h0 : cnt_reg[2:0]),
        .wdata (push_word),
        .raddr (rd_idx_reg),
        .rdata (error_word)
    );

    // ==================================================
    // Terminator check
    always @* begin
        ind_state_next = ind_state_reg;
        case (ind_state_reg)
            IND_SEARCH: begin
                if (scan_done && term_cnt_reg == 4'h1 && !term_seen) begin
                    ind_state_next = IND_SINGLE;
                end else if (scan_done && (term_cnt_reg > 4'h1 ||
                             (term_seen && term_cnt_reg != 4'h0))) begin
                    ind_state_next = IND_MULTI;
                end else if (scan_done && term_seen) begin
                    ind_state_next = IND_SINGLE;
                end
            end
            IND_SINGLE: begin
                if (term_seen) begin
                    ind_state_next = IND_MULTI;
                end
            end
            IND_MULTI: begin
                ind_state_next = IND_MULTI;
            end
            default: begin
                ind_state_next = IND_SEARCH;
            end
        endcase
        if (scan_go || clear_go) begin
            ind_state_next = IND_SEARCH;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_state_reg <= IND_SEARCH;
            term_cnt_reg  <= 4'h0;
        end else if (ce) begin
            ind_state_reg <= ind_state_next;
            if (scan_go || clear_go) begin
                term_cnt_reg <= 4'h0;
            end else if (term_seen && term_cnt_reg != 4'hF) begin
                term_cnt_reg <= term_cnt_reg + 4'h1;
            end
        end
    end

    rior_blink #(
        .HALF_CYC (BLINK_HALF_CYC)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (ind_state_reg == IND_MULTI),
        .phase   (blink_phase)
    );

    // ==================================================
    // Flag and indicator outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_flag                 <= 1'b0;
            terminator_check_indicator <= 1'b1;
        end else if (ce) begin
            error_flag <= fault_held_reg | (ind_state_reg == IND_MULTI);
            if (ind_state_reg == IND_SEARCH) begin
                terminator_check_indicator <= 1'b1;
            end else if (ind_state_reg == IND_MULTI) begin
                terminator_check_indicator <= blink_phase;
            end else begin
                terminator_check_indicator <= 1'b0;
            end
        end
    end

    // ==================================================
    // Control and interrupt registers
    wire [3:0] irq_set;
    assign irq_set[`RIOR_IRQ_FAULT]     = push & fault_valid;
    assign irq_set[`RIOR_IRQ_MULTI]     = (ind_state_next == IND_MULTI) &&
                                          (ind_state_reg != IND_MULTI);
    assign irq_set[`RIOR_IRQ_OVERFLOW]  = overflow;
    assign irq_set[`RIOR_IRQ_SCAN_DONE] = scan_done;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= `RIOR_CTRL_RESET;
            irq_stat_reg <= `RIOR_IRQ_RESET;
            irq_mask_reg <= `RIOR_IRQ_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata[2:0];
            end
            if (wr_mask) begin
                irq_mask_reg <= pwdata[3:0];
            end
            // Clear only what the read showed; a new set always wins
            if (rd_istat) begin
                irq_stat_reg <= (irq_stat_reg & ~prdata[3:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ==================================================
    // Read data, captured in the setup cycle for a zero-wait access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (rd_setup) begin
                if (paddr == `RIOR_OFF_CTRL) begin
                    prdata <= {29'h0, ctrl_reg};
                end else if (paddr == `RIOR_OFF_STATUS) begin
                    prdata <= {16'h0, term_cnt_reg, 1'b0, rd_idx_reg, cnt_reg,
                               terminator_check_indicator, ind_state_reg, error_flag};
                end else if (paddr == `RIOR_OFF_ERRWORD) begin
                    prdata <= {16'h0, error_word};
                end else if (paddr == `RIOR_OFF_IRQ_STAT) begin
                    prdata <= {28'h0, irq_stat_reg};
                end else if (paddr == `RIOR_OFF_IRQ_MASK) begin
                    prdata <= {28'h0, irq_mask_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== rior_defines.vh ====
// Constants of the remote I/O error reporter: offsets, fields, reset values, timing.
`ifndef RIOR_DEFINES_VH
`define RIOR_DEFINES_VH

// ==================================================
// Register offsets
`define RIOR_OFF_CTRL      12'h000
`define RIOR_OFF_STATUS    12'h004
`define RIOR_OFF_ERRWORD   12'h008
`define RIOR_OFF_IRQ_STAT  12'h00C
`define RIOR_OFF_IRQ_MASK  12'h010

// ==================================================
// Control fields
`define RIOR_CTRL_STEP_SMALL  0
`define RIOR_CTRL_STEP_LARGE  1
`define RIOR_CTRL_SMALL_VAR   2
`define RIOR_CTRL_SCAN_START  3
`define RIOR_CTRL_CLEAR       4
`define RIOR_CTRL_RESET       3'h0

// ==================================================
// Interrupt fields
`define RIOR_IRQ_FAULT      0
`define RIOR_IRQ_MULTI      1
`define RIOR_IRQ_OVERFLOW   2
`define RIOR_IRQ_SCAN_DONE  3
`define RIOR_IRQ_W          4
`define RIOR_IRQ_RESET      4'h0

// ==================================================
// Error word encoding
`define RIOR_UNIT_NIBBLE    4'hB
`define RIOR_MASTER_NIBBLE  4'h8
`define RIOR_KIND_MASTER    2'h0
`define RIOR_KIND_SLAVE     2'h1
`define RIOR_KIND_TERMINAL  2'h2
`define RIOR_TERM_ADDR_MAX  5'h1F

// ==================================================
// Queue and timing
`define RIOR_DEPTH          8
`define RIOR_PTR_W          3
`define RIOR_CNT_W          4
`define RIOR_CLK_KHZ        200000
`define RIOR_BLINK_HALF_MS  250

`endif

// ==== rior_fault_mem.v ====
// Fault entry memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
`include "rior_defines.vh"

module rior_fault_mem (
    input  wire        pclk,
    input  wire        ce,
    input  wire        we,
    input  wire [2:0]  waddr,
    input  wire [15:0] wdata,
    input  wire [2:0]  raddr,
    output reg  [15:0] rdata
);
    reg [15:0] mem [0:`RIOR_DEPTH-1];

    // No reset on the array; read data is only trusted once an entry exists
    always @(posedge pclk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ==== rior_blink.v ====
// Square-wave generator for the blinking indicator.
`timescale 1ns/10ps
`default_nettype none
`include "rior_defines.vh"

module rior_blink #(
    parameter [25:0] HALF_CYC = 26'd50000000
) (
    input  wire pclk,
    input  wire presetn,
    input  wire ce,
    input  wire run,
    output reg  phase
);
    reg [25:0] cnt_reg;

    // Restarts with lit phase so a blink always begins visibly
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 26'h0;
            phase   <= 1'b1;
        end else if (ce) begin
            if (!run) begin
                cnt_reg <= 26'h0;
                phase   <= 1'b1;
            end else if (cnt_reg >= HALF_CYC - 26'd1) begin
                cnt_reg <= 26'h0;
                phase   <= ~phase;
            end else begin
                cnt_reg <= cnt_reg + 26'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rior_assertions.sv ====
// Checker bound to the remote I/O error reporter top module.
`timescale 1ns/10ps
`default_nettype none
module rior_checker #(
    parameter [25:0] BLINK_HALF_CYC = 26'h0000004
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        fault_valid,
    input wire logic [1:0]  fault_kind,
    input wire logic        term_seen,
    input wire logic        scan_done,
    input wire logic [15:0] error_word,
    input wire logic        error_flag,
    input wire logic        terminator_check_indicator
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====================
    // Helper state
    logic        ctrl_wr;
    logic [3:0]  tcnt;
    logic        multi_h;
    logic [26:0] low_cnt;
    assign ctrl_wr = ce && psel && penable && pwrite && paddr == 12'h000;
    // Own terminator count, so the checker never trusts the block's status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt <= 4'h0;
            multi_h <= 1'b0;
            low_cnt <= 27'h0;
        end else if (ce) begin
            low_cnt <= terminator_check_indicator ? 27'h0 : low_cnt + 27'h1;
            if (ctrl_wr && (pwdata[3] || pwdata[4])) begin
                tcnt <= 4'h0;
                multi_h <= 1'b0;
            end else begin
                if (term_seen && tcnt != 4'hF) begin
                    tcnt <= tcnt + 4'h1;
                end
                if (scan_done && tcnt >= 4'h2) begin
                    multi_h <= 1'b1;
                end
            end
        end
    end
    // ====================
    // Properties
    flag_on_fault_a: assert property (ce && fault_valid && fault_kind != 2'h3 |-> ##2 error_flag)
        else $error("error flag missed a fault report");
    multi_enter_a: assert property (scan_done && !term_seen && tcnt >= 4'h2 |->
        ##2 error_flag && terminator_check_indicator)
        else $error("several terminators did not raise flag and lit indicator");
    unit_word_a: assert property (error_word[15:12] == 4'hB |->
        !error_word[11] && error_word[7:4] <= 4'h8 && error_word[3:0] == 4'h0)
        else $error("unit error word out of range");
    term_word_a: assert property (error_word[15:12] != 4'hB |-> error_word[15:12] <= 4'h3 &&
        error_word[11:8] <= 4'h9 && error_word[7:4] <= 4'h6 && !error_word[4])
        else $error("terminal error word out of range");
    ind_fall_a: assert property ($fell(terminator_check_indicator) && !error_flag |->
        $past(scan_done, 2))
        else $error("indicator went dark without a finished search");
    single_off_a: assert property (scan_done && !term_seen && tcnt == 4'h1 |->
        ##2 !terminator_check_indicator)
        else $error("indicator lit with exactly one terminator");
    blink_half_a: assert property (multi_h && $rose(terminator_check_indicator) |->
        low_cnt + 27'h1 >= {1'b0, BLINK_HALF_CYC} && low_cnt <= {1'b0, BLINK_HALF_CYC} + 27'h1)
        else $error("blink half period wrong");
    clear_search_a: assert property (ctrl_wr && pwdata[4] && !fault_valid |->
        ##2 terminator_check_indicator && !error_flag)
        else $error("clear did not restart the terminator search");
    cover property (scan_done && tcnt >= 4'h2);
    cover property (scan_done && tcnt == 4'h1);
    cover property (fault_valid ##2 error_flag);
endmodule
bind rior_top rior_checker #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_rior_checker (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .fault_valid,
    .fault_kind, .term_seen, .scan_done, .error_word, .error_flag, .terminator_check_indicator
);
`default_nettype wire

// ==== rior_link_model.sv ====
// Link-side model: fault reports and terminator detection pulses.
`timescale 1ns/10ps
`default_nettype none
module rior_link_model (
    input  wire logic  pclk,
    output logic       fault_valid,
    output logic [1:0] fault_kind,
    output logic [2:0] fault_master,
    output logic [2:0] fault_slave,
    output logic [4:0] fault_term_addr,
    output logic [1:0] fault_word_mult,
    output logic       term_seen,
    output logic [2:0] term_master,
    output logic [2:0] term_slave,
    output logic       scan_done
);
    initial begin
        {fault_valid, fault_kind, fault_master, fault_slave} = 9'h000;
        {fault_term_addr, fault_word_mult} = 7'h00;
        {term_seen, term_master, term_slave, scan_done} = 8'h00;
    end
    // Fields mean nothing without the strobe, so they are scrambled after it
    task automatic fault(input logic [1:0] k, input logic [2:0] m, input logic [2:0] s,
                         input logic [4:0] a, input logic [1:0] w);
        @(posedge pclk);
        fault_valid <= 1'b1;
        {fault_kind, fault_master, fault_slave, fault_term_addr, fault_word_mult} <= {k, m, s, a, w};
        @(posedge pclk);
        fault_valid <= 1'b0;
        {fault_kind, fault_master, fault_slave, fault_term_addr, fault_word_mult} <= ~{k, m, s, a, w};
    endtask
    task automatic term(input logic [2:0] m, input logic [2:0] s);
        @(posedge pclk);
        term_seen <= 1'b1;
        {term_master, term_slave} <= {m, s};
        @(posedge pclk);
        term_seen <= 1'b0;
        {term_master, term_slave} <= ~{m, s};
    endtask
    task automatic done;
        @(posedge pclk);
        scan_done <= 1'b1;
        @(posedge pclk);
        scan_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== test_rior_top.sv ====
// Self-checking testbench of the remote I/O error reporter.
`timescale 1ns/10ps
`default_nettype none
`include "rior_defines.vh"
module test_rior_top;
    // Short blink so a whole period fits in a few cycles
    localparam [25:0] HALF = 26'h0000004;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, ce;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        fault_valid, term_seen, scan_done, error_flag, terminator_check_indicator;
    logic [1:0]  fault_kind, fault_word_mult;
    logic [2:0]  fault_master, fault_slave, term_master, term_slave;
    logic [4:0]  fault_term_addr;
    logic [15:0] error_word;
    int          bad_count, num_checks;
    rior_top #(.BLINK_HALF_CYC(HALF)) u_rior_top (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fault_valid, .fault_kind, .fault_master, .fault_slave,
        .fault_term_addr, .fault_word_mult, .term_seen, .term_master, .term_slave,
        .scan_done, .error_word, .error_flag, .terminator_check_indicator, .irq
    );
    rior_link_model u_rior_link_model (
        .pclk, .fault_valid, .fault_kind, .fault_master, .fault_slave, .fault_term_addr,
        .fault_word_mult, .term_seen, .term_master, .term_slave, .scan_done
    );
    always #2.5 pclk = ~pclk;
    // ====================
    // Bus and compare tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask
    task automatic chk_ew(input logic [15:0] e);
        chk_word({16'h0000, error_word}, {16'h0000, e});
    endtask
    function automatic logic [7:0] bcd(input logic [4:0] a);
        return {4'(a / 5'h0A), 4'(a % 5'h0A)};
    endfunction
    task automatic step(input logic [31:0] on, input logic [31:0] off,
                        input logic [15:0] cur, input logic [15:0] nxt);
        wr(`RIOR_OFF_CTRL, on);
        waitc(3);
        chk_ew(cur);
        wr(`RIOR_OFF_CTRL, off);
        waitc(3);
        chk_ew(nxt);
    endtask
    // ====================
    // Scenarios
    task automatic s_regs;
        apb(1'b0, `RIOR_OFF_STATUS, 32'h0);
        chk_word(rd, 32'h00000008);
        apb(1'b0, 12'h014, 32'h0);
        chk_bit(err, 1'b1);
        wr(`RIOR_OFF_CTRL, 32'h0000001F);
        apb(1'b0, `RIOR_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h00000007);
        wr(`RIOR_OFF_CTRL, 32'h00000000);
    endtask
    task automatic s_faults;
        logic [15:0] q [6];
        q[0] = 16'hB280;
        q[1] = 16'hB150;
        wr(`RIOR_OFF_CTRL, 32'h00000010);
        u_rior_link_model.fault(2'h0, 3'h2, 3'h6, 5'h0A, 2'h1);
        u_rior_link_model.fault(2'h1, 3'h1, 3'h5, 5'h0B, 2'h2);
        for (int i = 0; i < 4; i++) begin
            u_rior_link_model.fault(2'h2, 3'h4, 3'h3, 5'h1C + 5'(i), 2'(i));
            q[i + 2] = {bcd(5'h1C + 5'(i)), 1'b0, 2'(i), 1'b0, 4'h0};
        end
        u_rior_link_model.fault(2'h3, 3'h0, 3'h1, 5'h01, 2'h0);
        waitc(2);
        chk_ew(q[0]);
        chk_bit(error_flag, 1'b1);
        chk_bit(irq, 1'b0);
        apb(1'b0, `RIOR_OFF_STATUS, 32'h0);
        chk_word(rd & 32'h000000F0, 32'h00000060);
        for (int i = 0; i < 6; i++) begin
            step(32'h00000002, 32'h00000000, q[i], q[(i + 1) % 6]);
        end
        wr(`RIOR_OFF_IRQ_MASK, 32'h00000001);
        waitc(1);
        chk_bit(irq, 1'b1);
        apb(1'b0, `RIOR_OFF_IRQ_STAT, 32'h0);
        chk_word(rd & 32'h00000005, 32'h00000001);
        waitc(1);
        chk_bit(irq, 1'b0);
    endtask
    task automatic s_small;
        wr(`RIOR_OFF_CTRL, 32'h00000014);
        u_rior_link_model.fault(2'h1, 3'h5, 3'h3, 5'h00, 2'h0);
        u_rior_link_model.fault(2'h2, 3'h0, 3'h0, 5'h07, 2'h3);
        step(32'h00000005, 32'h00000004, 16'hB110, 16'h0700);
    endtask
    task automatic s_ovf;
        wr(`RIOR_OFF_CTRL, 32'h00000010);
        for (int i = 0; i < 9; i++) begin
            u_rior_link_model.fault(2'h1, 3'h0, 3'(i), 5'h00, 2'h0);
        end
        waitc(2);
        chk_ew(16'hB000);
        apb(1'b0, `RIOR_OFF_STATUS, 32'h0);
        chk_word(rd & 32'h000000F0, 32'h00000080);
        apb(1'b0, `RIOR_OFF_IRQ_STAT, 32'h0);
        chk_word(rd & 32'h00000004, 32'h00000004);
    endtask
    task automatic s_term;
        int n;
        logic p;
        wr(`RIOR_OFF_CTRL, 32'h00000018);
        waitc(2);
        chk_bit(terminator_check_indicator, 1'b1);
        u_rior_link_model.term(3'h1, 3'h2);
        u_rior_link_model.done();
        waitc(2);
        chk_bit(terminator_check_indicator, 1'b0);
        chk_bit(error_flag, 1'b0);
        chk_ew(16'hB120);
        wr(`RIOR_OFF_IRQ_MASK, 32'h00000002);
        u_rior_link_model.term(3'h3, 3'h4);
        waitc(2);
        chk_bit(terminator_check_indicator, 1'b1);
        chk_bit(error_flag, 1'b1);
        chk_bit(irq, 1'b1);
        apb(1'b0, `RIOR_OFF_IRQ_STAT, 32'h0);
        chk_word(rd & 32'h00000002, 32'h00000002);
        waitc(1);
        chk_bit(irq, 1'b0);
        wr(`RIOR_OFF_CTRL, 32'h00000018);
        for (int i = 0; i < 3; i++) begin
            u_rior_link_model.term(3'(i), 3'(i));
        end
        u_rior_link_model.done();
        waitc(2);
        chk_bit(terminator_check_indicator, 1'b1);
        n = 0;
        p = terminator_check_indicator;
        repeat (12) begin
            waitc(1);
            if (terminator_check_indicator !== p) n++;
            p = terminator_check_indicator;
        end
        chk_bit(n >= 2, 1'b1);
        apb(1'b0, `RIOR_OFF_STATUS, 32'h0);
        chk_word(rd & 32'h0000F006, 32'h00003002);
        // Clock enable low must freeze the blink; 4 edges hold one toggle
        ce <= 1'b0;
        waitc(1);
        p = terminator_check_indicator;
        waitc(4);
        chk_bit(terminator_check_indicator, p);
        ce <= 1'b1;
    endtask
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ====================
    // Main sequence and watchdog
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        s_regs;
        s_faults;
        s_small;
        s_ovf;
        s_term;
        close_out;
    end
    initial begin
        #100000;
        bad_count++;
        close_out;
    end
endmodule
`default_nettype wire
